// ==== logic/speep_top.sv ====
// module: serial eeprom slave, pins sampled by the system clock
`timescale 1ns/1ps
`default_nettype none
module speep_top #(
  parameter int PROG_CYC = speep_pkg::PROG_CYC_DEF // programming length in cycles
) (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic cs_n_i,
  input  wire logic sck_i,
  input  wire logic si_i,
  input  wire logic hold_n_i,
  input  wire logic wp_n_i,
  output logic      so_o,
  output logic      so_oe_o,
  output logic      busy_o
);
  ////////////////////////////////////////////////////////////////////////
  // whole state of the slave
  typedef struct packed {
    logic cs_m, cs_s, cs_d;       // select synchroniser and delay
    logic sck_m, sck_s, sck_d;    // clock synchroniser and delay
    logic si_m, si_s;             // data-in synchroniser
    logic hold_m, hold_s;         // pause synchroniser
    logic wp_m, wp_s, wp_d;       // guard pin synchroniser and delay
    speep_pkg::speep_phase_t phase;
    logic [7:0]  shreg;           // incoming bits
    logic [2:0]  ibit;            // bits of current input byte
    logic [4:0]  acnt;            // address bits taken
    logic [15:0] addr;            // address shifted in
    logic        is_rd;           // address phase belongs to a read
    logic [7:0]  obuf;            // outgoing bits
    logic [2:0]  obit;            // bits of current output byte
    logic        drive, so, so_oe;
    logic        arm, arm_set, arm_clr;
    logic        guard_en, page_sel, lip;
    logic [1:0]  bp;
    logic        busy, prog_sr, prog_id;
    logic [speep_pkg::PROG_W-1:0] cnt;
    logic [7:0]  wdata;           // data byte of a write
    logic        wgot;
    logic [7:0]  srnew;           // new status byte
    logic        srgot, abort;
    logic [15:0] faddr;           // prefetch pointer
    logic        fid, fetch_on, rd_pend;
  } speep_state_t;
  speep_state_t s_ff;
  speep_state_t nxt_s;
  logic        sck_rise;   // sampled rising edge, selected, not paused
  logic        sck_fall;   // sampled falling edge, selected, not paused
  logic        cs_rise;    // end of frame
  logic        wp_fall;    // guard pin dropped
  logic        rd_issue;   // prefetch read this cycle
  logic        pop;        // output shifter takes a byte
  logic        wr_start;   // array programming starts
  logic [7:0]  mem_rdata;
  speep_strm_if #(.W(speep_pkg::DATA_W)) fill_if ();
  speep_strm_if #(.W(speep_pkg::DATA_W)) drain_if ();
  ////////////////////////////////////////////////////////////////////////
  // block-guard check on a 16-bit address
  function automatic logic guarded(input logic [1:0] bp, input logic [15:0] a);
    unique case (bp)
      2'h0: guarded = 1'b0;
      2'h1: guarded = (a[15:14] == 2'h3);
      2'h2: guarded = a[15];
      2'h3: guarded = 1'b1;
    endcase
  endfunction
  // status byte as the host sees it
  function automatic logic [7:0] status_of(input speep_state_t st);
    status_of = 8'h00;
    status_of[speep_pkg::SR_BUSY] = st.busy;
    status_of[speep_pkg::SR_ARM]      = st.arm;
    status_of[speep_pkg::SR_GUARD0]   = st.bp[0];
    status_of[speep_pkg::SR_GUARD1]   = st.bp[1];
    status_of[speep_pkg::SR_LIP]      = st.lip;
    status_of[speep_pkg::SR_PAGE_SEL] = st.page_sel;
    status_of[speep_pkg::SR_GUARD_EN] = st.guard_en;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // edge detection reads only second-stage and delay flops
  assign sck_rise = s_ff.sck_s & ~s_ff.sck_d & ~s_ff.cs_s & s_ff.hold_s;
  assign sck_fall = ~s_ff.sck_s & s_ff.sck_d & ~s_ff.cs_s & s_ff.hold_s;
  assign cs_rise  = s_ff.cs_s & ~s_ff.cs_d;
  assign wp_fall  = s_ff.wp_d & ~s_ff.wp_s;
  // prefetch runs while the fifo has room; the shifter is the stall point
  assign rd_issue = s_ff.fetch_on & ~s_ff.rd_pend & fill_if.ready & ~s_ff.cs_s;
  assign pop      = sck_fall & (s_ff.phase == speep_pkg::P_RDATA) & (s_ff.obit == 3'h0);
  assign fill_if.valid  = s_ff.rd_pend;
  assign fill_if.data   = mem_rdata;
  assign drain_if.ready = pop;
  // a byte write is allowed with the latch set and the target unguarded
  assign wr_start = cs_rise & (s_ff.phase == speep_pkg::P_WDATA) & s_ff.wgot
                  & (s_ff.ibit == 3'h0) & s_ff.arm
                  & (s_ff.page_sel ? (s_ff.bp != 2'h3) & ~s_ff.lip
                                & ~guarded(s_ff.bp, {9'h000, s_ff.addr[6:0]})
                              : ~guarded(s_ff.bp, s_ff.addr));
  ////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    logic [7:0] byte_in;
    logic [7:0] nbyte;
    byte_in = {s_ff.shreg[6:0], s_ff.si_s};
    nbyte   = 8'h00;
    nxt_s   = s_ff;
    // two-flop synchronisers and edge delays
    nxt_s.cs_m   = cs_n_i;
    nxt_s.cs_s   = s_ff.cs_m;
    nxt_s.cs_d   = s_ff.cs_s;
    nxt_s.sck_m  = sck_i;
    nxt_s.sck_s  = s_ff.sck_m;
    nxt_s.sck_d  = s_ff.sck_s;
    nxt_s.si_m   = si_i;
    nxt_s.si_s   = s_ff.si_m;
    nxt_s.hold_m = hold_n_i;
    nxt_s.hold_s = s_ff.hold_m;
    nxt_s.wp_m   = wp_n_i;
    nxt_s.wp_s   = s_ff.wp_m;
    nxt_s.wp_d   = s_ff.wp_s;
    nxt_s.rd_pend = rd_issue;
    // prefetch pointer: seven bits on the id page, sixteen on the array
    if (rd_issue) begin
      if (s_ff.fid) begin
        nxt_s.faddr = {9'h000, s_ff.faddr[6:0] + 7'h01};
      end else begin
        nxt_s.faddr = s_ff.faddr + 16'h0001;
      end
    end
    // a guard-pin drop during the status-write frame kills it
    if (wp_fall && (s_ff.phase == speep_pkg::P_SRW)) begin
      nxt_s.abort = 1'b1;
    end
    // frame start
    if (!s_ff.cs_s && (s_ff.phase == speep_pkg::P_IDLE)) begin
      nxt_s.phase = speep_pkg::P_CMD;
      nxt_s.ibit  = 3'h0;
      nxt_s.obit  = 3'h0;
      nxt_s.acnt  = 5'h00;
      nxt_s.wgot  = 1'b0;
      nxt_s.srgot = 1'b0;
      nxt_s.abort = 1'b0;
      nxt_s.arm_set = 1'b0;
      nxt_s.arm_clr = 1'b0;
    end
    // sampling edge: shift in, msb first
    if (sck_rise) begin
      nxt_s.shreg = byte_in;
      nxt_s.ibit  = s_ff.ibit + 3'h1;
      unique case (s_ff.phase)
        speep_pkg::P_CMD: begin
          if (s_ff.ibit == 3'h7) begin
            if (s_ff.busy && (byte_in != speep_pkg::OP_STATUS_READ)) begin
              nxt_s.phase = speep_pkg::P_IGNORE;
            end else begin
              unique case (byte_in)
                speep_pkg::OP_READ: begin
                  nxt_s.phase = speep_pkg::P_ADDR;
                  nxt_s.is_rd = 1'b1;
                end
                speep_pkg::OP_WRITE: begin
                  nxt_s.phase = speep_pkg::P_ADDR;
                  nxt_s.is_rd = 1'b0;
                end
                speep_pkg::OP_STATUS_READ: nxt_s.phase = speep_pkg::P_SRD;
                speep_pkg::OP_WRSR: nxt_s.phase = speep_pkg::P_SRW;
                speep_pkg::OP_WRITE_ARM: begin
                  nxt_s.arm_set = 1'b1;
                  nxt_s.phase   = speep_pkg::P_IGNORE;
                end
                speep_pkg::OP_WRDI: begin
                  nxt_s.arm_clr = 1'b1;
                  nxt_s.phase   = speep_pkg::P_IGNORE;
                end
                default: nxt_s.phase = speep_pkg::P_IGNORE;
              endcase
            end
          end
        end
        speep_pkg::P_ADDR: begin
          nxt_s.addr = {s_ff.addr[14:0], s_ff.si_s};
          nxt_s.acnt = s_ff.acnt + 5'h01;
          if (s_ff.acnt == 5'h0f) begin
            nxt_s.ibit = 3'h0;
            if (s_ff.is_rd) begin
              nxt_s.phase    = speep_pkg::P_RDATA;
              nxt_s.fetch_on = 1'b1;
              nxt_s.fid      = s_ff.page_sel;
              nxt_s.faddr    = s_ff.page_sel ? {9'h000, s_ff.addr[5:0], s_ff.si_s}
                                        : {s_ff.addr[14:0], s_ff.si_s};
            end else begin
              nxt_s.phase = speep_pkg::P_WDATA;
            end
          end
        end
        speep_pkg::P_WDATA: begin
          // only the first data byte is kept
          if ((s_ff.ibit == 3'h7) && !s_ff.wgot) begin
            nxt_s.wdata = byte_in;
            nxt_s.wgot  = 1'b1;
          end
        end
        speep_pkg::P_SRW: begin
          if ((s_ff.ibit == 3'h7) && !s_ff.srgot) begin
            nxt_s.srnew = byte_in;
            nxt_s.srgot = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // shifting edge: next bit out, msb first
    if (sck_fall && ((s_ff.phase == speep_pkg::P_RDATA) || (s_ff.phase == speep_pkg::P_SRD))) begin
      if (s_ff.obit == 3'h0) begin
        if (s_ff.phase == speep_pkg::P_RDATA) begin
          nbyte = drain_if.valid ? drain_if.data : 8'hff;
        end else begin
          nbyte = status_of(s_ff);
        end
        nxt_s.so   = nbyte[7];
        nxt_s.obuf = {nbyte[6:0], 1'b0};
      end else begin
        nxt_s.so   = s_ff.obuf[7];
        nxt_s.obuf = {s_ff.obuf[6:0], 1'b0};
      end
      nxt_s.obit  = s_ff.obit + 3'h1;
      nxt_s.drive = 1'b1;
    end
    // programming cycle; the guard pin is no longer looked at here
    if (s_ff.busy) begin
      if (s_ff.cnt == '0) begin
        nxt_s.busy = 1'b0;
        nxt_s.arm  = 1'b0;
        if (s_ff.prog_sr) begin
          nxt_s.guard_en = s_ff.srnew[speep_pkg::SR_GUARD_EN];
          nxt_s.bp   = {s_ff.srnew[speep_pkg::SR_GUARD1], s_ff.srnew[speep_pkg::SR_GUARD0]};
          // both page bits at once leaves them unchanged
          if (!(s_ff.srnew[speep_pkg::SR_PAGE_SEL] && s_ff.srnew[speep_pkg::SR_LIP])) begin
            nxt_s.page_sel = s_ff.srnew[speep_pkg::SR_PAGE_SEL];
            nxt_s.lip = s_ff.lip | s_ff.srnew[speep_pkg::SR_LIP];
          end
        end
        if (s_ff.prog_id) begin
          nxt_s.page_sel = 1'b0;
        end
      end else begin
        nxt_s.cnt = s_ff.cnt - 1'b1;
      end
    end
    // frame end
    if (cs_rise) begin
      nxt_s.phase    = speep_pkg::P_IDLE;
      nxt_s.drive    = 1'b0;
      nxt_s.fetch_on = 1'b0;
      nxt_s.rd_pend  = 1'b0;
      if (s_ff.arm_set && (s_ff.ibit == 3'h0)) begin
        nxt_s.arm = 1'b1;
      end
      if (s_ff.arm_clr && (s_ff.ibit == 3'h0)) begin
        nxt_s.arm = 1'b0;
      end
      if ((s_ff.phase == speep_pkg::P_RDATA) && (s_ff.obit != 3'h0 || s_ff.fid)) begin
        nxt_s.page_sel = 1'b0;
      end
      if (wr_start) begin
        nxt_s.busy    = 1'b1;
        nxt_s.prog_sr = 1'b0;
        nxt_s.prog_id = s_ff.page_sel;
        nxt_s.cnt     = speep_pkg::PROG_W'(PROG_CYC - 1);
      end
      // status write needs the latch, a whole-byte length, no abort and no guard
      if ((s_ff.phase == speep_pkg::P_SRW) && s_ff.srgot && (s_ff.ibit == 3'h0)
          && s_ff.arm && !s_ff.abort && !(s_ff.guard_en && !s_ff.wp_s)) begin
        nxt_s.busy    = 1'b1;
        nxt_s.prog_sr = 1'b1;
        nxt_s.prog_id = 1'b0;
        nxt_s.cnt     = speep_pkg::PROG_W'(PROG_CYC - 1);
      end
    end
    // output enable follows drive and drops during a pause
    nxt_s.so_oe = nxt_s.drive & s_ff.hold_s;
  end
  ////////////////////////////////////////////////////////////////////////
  // state register; select, pause and guard pins idle high, write latch clear
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_ff        <= '0;
      s_ff.cs_m   <= speep_pkg::PIN_IDLE_HI;
      s_ff.cs_s   <= speep_pkg::PIN_IDLE_HI;
      s_ff.cs_d   <= speep_pkg::PIN_IDLE_HI;
      s_ff.hold_m <= speep_pkg::PIN_IDLE_HI;
      s_ff.hold_s <= speep_pkg::PIN_IDLE_HI;
      s_ff.wp_m   <= speep_pkg::PIN_IDLE_HI;
      s_ff.wp_s   <= speep_pkg::PIN_IDLE_HI;
      s_ff.wp_d   <= speep_pkg::PIN_IDLE_HI;
      s_ff.arm    <= speep_pkg::ARM_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end
  assign so_o    = s_ff.so;
  assign so_oe_o = s_ff.so_oe;
  assign busy_o  = s_ff.busy;
  ////////////////////////////////////////////////////////////////////////
  // storage and read-ahead buffer
  speep_mem #(.AW(speep_pkg::MEM_AW), .W(speep_pkg::DATA_W)) u_mem (
    .clk_i   (sys_clk_i),
    .we_i    (wr_start),
    .waddr_i ({s_ff.page_sel, s_ff.page_sel ? {9'h000, s_ff.addr[6:0]} : s_ff.addr}),
    .wdata_i (s_ff.wdata),
    .re_i    (rd_issue),
    .raddr_i ({s_ff.fid, s_ff.faddr}),
    .rdata_o (mem_rdata)
  );
  speep_fifo #(.W(speep_pkg::DATA_W), .DEPTH(speep_pkg::FIFO_DEPTH)) u_fifo (
    .clk_i   (sys_clk_i),
    .rst_i   (rst_i),
    .flush_i (cs_rise),
    .in_if   (fill_if),
    .out_if  (drain_if)
  );
  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sr_refuse_a: assert property (cs_rise && s_ff.phase == speep_pkg::P_SRW && s_ff.guard_en
    && !s_ff.wp_s |=> !s_ff.busy) else $error("status write passed the guard");
  wp_abort_a: assert property (wp_fall && s_ff.phase == speep_pkg::P_SRW
    |=> s_ff.abort) else $error("guard drop did not abort");
  prog_keep_a: assert property (s_ff.busy && s_ff.cnt != '0 && wp_fall
    |=> s_ff.busy) else $error("guard drop disturbed programming");
  wp_ignore_a: assert property (cs_rise && s_ff.phase == speep_pkg::P_SRW && s_ff.srgot
    && s_ff.ibit == 3'h0 && s_ff.arm && !s_ff.guard_en && !s_ff.abort
    |=> s_ff.busy && s_ff.prog_sr) else $error("status write not started");
  read_go_a: assert property (sck_rise && s_ff.phase == speep_pkg::P_ADDR && s_ff.is_rd
    && s_ff.acnt == 5'h0f |=> s_ff.phase == speep_pkg::P_RDATA ##[1:4] drain_if.valid)
    else $error("read data not ready");
  ptr_wrap_a: assert property (rd_issue && !s_ff.fid && s_ff.faddr == 16'hffff
    |=> s_ff.faddr == 16'h0000) else $error("pointer did not wrap");
  frame_end_a: assert property (cs_rise |=> s_ff.phase == speep_pkg::P_IDLE
    ##1 !so_oe_o) else $error("frame did not end");
  pause_float_a: assert property (!s_ff.hold_s |=> !so_oe_o)
    else $error("output driven in pause");
  arm_clear_a: assert property ($fell(s_ff.busy) |-> !s_ff.arm)
    else $error("write latch left set");
  busy_ign_a: assert property (s_ff.busy && s_ff.cnt > 2 && sck_rise
    && s_ff.phase == speep_pkg::P_CMD && s_ff.ibit == 3'h7
    && {s_ff.shreg[6:0], s_ff.si_s} != speep_pkg::OP_STATUS_READ
    |=> s_ff.phase == speep_pkg::P_IGNORE) else $error("command taken while busy");
  bad_op_a: assert property (s_ff.phase == speep_pkg::P_IGNORE [*2] |-> !so_oe_o)
    else $error("output driven after bad opcode");
  read_cv: cover property (s_ff.phase == speep_pkg::P_RDATA && pop);
  busy_poll_cv: cover property (s_ff.busy && s_ff.phase == speep_pkg::P_SRD && sck_fall);
  pause_cv: cover property (s_ff.phase == speep_pkg::P_RDATA && !s_ff.hold_s);
endmodule
`default_nettype wire

// ==== logic/speep_pkg.sv ====
// package: constants and types shared by the serial eeprom slave
package speep_pkg;
  // opcodes
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_WRITE_ARM = 8'h06;
  // status register field positions
  localparam int SR_BUSY = 0;
  localparam int SR_ARM = 1;
  localparam int SR_GUARD0 = 2;
  localparam int SR_GUARD1 = 3;
  localparam int SR_LIP = 4;
  localparam int SR_PAGE_SEL = 6;
  localparam int SR_GUARD_EN = 7;
  // sizes
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  localparam int MEM_AW = 17;
  localparam int FIFO_DEPTH = 4;
  localparam int PROG_W = 18;
  // values after reset
  localparam logic PIN_IDLE_HI = 1'b1;
  localparam logic ARM_RST = 1'b0;
  // timing: longest programming time rounds down to whole cycles
  localparam int CLK_NS = 20;
  localparam int T_WC_NS = 5000000;
  localparam int PROG_CYC_DEF = T_WC_NS / CLK_NS;
  // serial phases
  typedef enum logic [2:0] {
    P_IDLE, P_CMD, P_ADDR, P_RDATA, P_WDATA, P_SRD, P_SRW, P_IGNORE
  } speep_phase_t;
endpackage

// ==== logic/speep_strm_if.sv ====
// interface: valid/ready byte stream between the slave and its fifo
`timescale 1ns/1ps
`default_nettype none
interface speep_strm_if #(parameter int W = 8);
  logic         valid; // producer has a word
  logic         ready; // consumer takes it this cycle
  logic [W-1:0] data;  // the word
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== logic/speep_fifo.sv ====
// module: small parameterised fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module speep_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  input wire logic    clk_i,
  input wire logic    rst_i,
  input wire logic    flush_i,
  speep_strm_if.snk   in_if,
  speep_strm_if.src   out_if
);
  localparam int AW = $clog2(DEPTH);
  // whole fifo state; depth must be a power of two so pointers wrap
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] cells;
    logic [AW-1:0]           wr_ptr;
    logic [AW-1:0]           rd_ptr;
    logic [AW:0]             count;
  } speep_fifo_st_t;
  speep_fifo_st_t s_ff;
  speep_fifo_st_t nxt_s;
  logic           push;
  logic           pop;
  ////////////////////////////////////////////////////////////////////////
  // honest full and empty flags
  assign in_if.ready  = (s_ff.count != (AW+1)'(DEPTH));
  assign out_if.valid = (s_ff.count != '0);
  assign out_if.data  = s_ff.cells[s_ff.rd_ptr];
  assign push         = in_if.valid & in_if.ready;
  assign pop          = out_if.valid & out_if.ready;
  // next state; flush wins so a late word never survives a new frame
  always_comb begin
    nxt_s = s_ff;
    if (push) begin
      nxt_s.cells[s_ff.wr_ptr] = in_if.data;
      nxt_s.wr_ptr = s_ff.wr_ptr + 1'b1;
    end
    if (pop) begin
      nxt_s.rd_ptr = s_ff.rd_ptr + 1'b1;
    end
    nxt_s.count = s_ff.count + (AW+1)'(push) - (AW+1)'(pop);
    if (flush_i) begin
      nxt_s.wr_ptr = '0;
      nxt_s.rd_ptr = '0;
      nxt_s.count  = '0;
    end
  end
  // state register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end
endmodule
`default_nettype wire

// ==== logic/speep_mem.sv ====
// module: byte array with registered read data (main array plus id page)
`timescale 1ns/1ps
`default_nettype none
module speep_mem #(
  parameter int AW = 17,
  parameter int W  = 8
) (
  input  wire logic          clk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [W-1:0]  wdata_i,
  input  wire logic          re_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [W-1:0]  rdata_o
);
  logic [W-1:0] cells [0:(2**AW)-1]; // storage, no reset: contents are data
  logic [W-1:0] rdata_ff;            // read data register
  // one write port, one read port, read data valid the cycle after re_i
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      cells[waddr_i] <= wdata_i;
    end
    if (re_i) begin
      rdata_ff <= cells[raddr_i];
    end
  end
  assign rdata_o = rdata_ff;
endmodule
`default_nettype wire

// ==== test/speep_host.sv ====
// host model: serial bus master that drives the eeprom slave pins
`timescale 1ns/1ps
`default_nettype none
module speep_host (
  input  wire logic clk_i,
  output logic      cs_n_o,
  output logic      sck_o,
  output logic      si_o,
  output logic      hold_n_o,
  output logic      wp_n_o,
  input  wire logic so_i
);
  // idle pins: deselected, clock parked low between frames
  initial begin
    cs_n_o   = 1'b1;
    sck_o    = 1'b0;
    si_o     = 1'b0;
    hold_n_o = 1'b1;
    wp_n_o   = 1'b1;
  end
  // pins only move on the system clock's falling edge
  task automatic fe(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // open a frame
  task automatic sel();
    fe(4);
    cs_n_o = 1'b0;
    fe(4);
  endtask
  // close on a whole byte; the slave starts programming here
  task automatic desel();
    sck_o = 1'b0;
    fe(4);
    cs_n_o = 1'b1;
    si_o   = ~si_o; // released line shows no stale value
    fe(6);
  endtask
  // one byte msb first; data set with clock low, read late in high
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck_o = 1'b0;
      si_o  = tx[i];
      fe(4);
      sck_o = 1'b1;
      fe(4);
      rx[i] = so_i;
    end
  endtask
  // pause moves only while clock low, select kept low throughout
  task automatic pause(input logic lvl);
    sck_o = 1'b0;
    fe(2);
    hold_n_o = lvl;
    fe(6);
  endtask
  // page reads are never clocked past the page end here
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// bench: drives the eeprom slave through the host model and judges it
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       sys_clk_i  = 1'b0; // 50 MHz system clock
  logic       rst_i      = 1'b1; // power-on reset
  logic       cs_n, sck, si, hold_n, wp_n, so, so_oe, busy;
  logic [7:0] rx;                // byte the host saw
  int         failures   = 0;
  int         n_compared = 0;
  // free-running clock
  always #10 sys_clk_i = ~sys_clk_i;
  // short programming time keeps the run small
  speep_top #(.PROG_CYC(400)) speep_top_i (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sck_i(sck),
    .si_i(si), .hold_n_i(hold_n), .wp_n_i(wp_n), .so_o(so),
    .so_oe_o(so_oe), .busy_o(busy));
  speep_host speep_host_i (
    .clk_i(sys_clk_i), .cs_n_o(cs_n), .sck_o(sck), .si_o(si),
    .hold_n_o(hold_n), .wp_n_o(wp_n), .so_i(so));
  //////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (failures == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // frame of one or two bytes; f pulses the guard pin low mid-frame,
  // back high before closing so only the abort can refuse the write
  task automatic frm(input logic [7:0] a, input logic [7:0] b, input bit two, input bit f);
    speep_host_i.sel();
    speep_host_i.xfer(a, rx);
    if (two) speep_host_i.xfer(b, rx);
    if (f) begin
      speep_host_i.wp_n_o = 1'b0;
      speep_host_i.fe(6);
      speep_host_i.wp_n_o = 1'b1;
      speep_host_i.fe(6);
    end
    speep_host_i.desel();
  endtask
  // status read: the second byte is the register
  task automatic sread(output logic [7:0] st);
    speep_host_i.sel();
    speep_host_i.xfer(speep_pkg::OP_STATUS_READ, st);
    speep_host_i.xfer(8'h00, st);
    speep_host_i.desel();
  endtask
  // bounded wait for programming to finish
  task automatic idle();
    for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(negedge sys_clk_i);
    check({7'h00, busy}, 8'h00);
  endtask
  // armed byte write; status polled while busy and after
  task automatic t_write(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] st;
    frm(speep_pkg::OP_WRITE_ARM, 8'h00, 0, 0);
    speep_host_i.sel();
    speep_host_i.xfer(speep_pkg::OP_WRITE, rx);
    speep_host_i.xfer(a[15:8], rx);
    speep_host_i.xfer(a[7:0], rx);
    speep_host_i.xfer(d, rx);
    speep_host_i.desel();
    check({7'h00, busy}, 8'h01);
    sread(st);
    check(st, 8'h03);
    idle();
    sread(st);
    check(st, 8'h00);
  endtask
  // read across the top address; select high ends it
  task automatic t_read();
    t_write(16'hffff, 8'ha5);
    t_write(16'h0000, 8'h5a);
    t_write(16'h0001, 8'hc3);
    speep_host_i.sel();
    speep_host_i.xfer(speep_pkg::OP_READ, rx);
    speep_host_i.xfer(8'hff, rx);
    speep_host_i.xfer(8'hff, rx);
    speep_host_i.xfer(8'h00, rx);
    check(rx, 8'ha5);
    speep_host_i.xfer(8'h00, rx);
    check(rx, 8'h5a);
    speep_host_i.xfer(8'h00, rx);
    check(rx, 8'hc3);
    speep_host_i.desel();
    check({7'h00, so_oe}, 8'h00);
  endtask
  // unknown opcode, then a pause in mid status read
  task automatic t_odd();
    speep_host_i.sel();
    speep_host_i.xfer(8'h0b, rx);
    speep_host_i.xfer(8'h00, rx);
    check({7'h00, so_oe}, 8'h00);
    speep_host_i.desel();
    speep_host_i.sel();
    speep_host_i.xfer(speep_pkg::OP_STATUS_READ, rx);
    speep_host_i.xfer(8'h00, rx);
    speep_host_i.pause(1'b0);
    check({7'h00, so_oe}, 8'h00);
    speep_host_i.pause(1'b1);
    speep_host_i.desel();
  endtask
  // guard pin ignored until enabled, then refuses and aborts
  task automatic t_guard();
    speep_host_i.wp_n_o = 1'b0;
    frm(speep_pkg::OP_WRITE_ARM, 8'h00, 0, 0);
    frm(speep_pkg::OP_WRSR, 8'h80, 1, 0);
    idle();
    sread(rx);
    check(rx, 8'h80);
    frm(speep_pkg::OP_WRITE_ARM, 8'h00, 0, 0);
    frm(speep_pkg::OP_WRSR, 8'h8c, 1, 0);
    check({7'h00, busy}, 8'h00);
    sread(rx);
    check(rx & 8'hfc, 8'h80);
    speep_host_i.wp_n_o = 1'b1;
    frm(speep_pkg::OP_WRITE_ARM, 8'h00, 0, 0);
    frm(speep_pkg::OP_WRSR, 8'h8c, 1, 1);
    check({7'h00, busy}, 8'h00);
    sread(rx);
    check(rx & 8'hfc, 8'h80);
  endtask
  // main sequence
  initial begin
    repeat (12) @(negedge sys_clk_i);
    rst_i = 1'b0;
    sread(rx);
    check(rx, 8'h00);
    t_read();
    t_odd();
    t_guard();
    final_report();
  end
  // watchdog well past the expected run length
  initial begin
    #1000000;
    failures++;
    final_report();
  end
endmodule
`default_nettype wire
